// File: cts_defs.vh
`ifndef CTS_DEFS_VH
`define CTS_DEFS_VH

// register byte offsets on the bus
`define CTS_OFF_TXIRQ_LO 8'h00
`define CTS_OFF_TXIRQ_HI 8'h04
`define CTS_OFF_ATT_LO 8'h08
`define CTS_OFF_ATT_HI 8'h0C
`define CTS_OFF_SREQ_LO 8'h10
`define CTS_OFF_SREQ_HI 8'h14
`define CTS_OFF_BASE_HI 8'h18
`define CTS_OFF_EV_STAT 8'h1C
`define CTS_OFF_EV_MASK 8'h20

// address decode width
`define CTS_AW 8
`define CTS_DW 32

// channel count and per-channel transmit flag count
`define CTS_NCH 8
`define CTS_NFLG 3

// field positions inside event status and mask
`define CTS_EV_DONE_LSB 0
`define CTS_EV_ATT_LSB 8
`define CTS_EV_W 16

// reset values
`define CTS_RST_16 16'h0000
`define CTS_RST_32 32'h0000_0000
`define CTS_RST_8 8'h00

// the base address keeps its two lowest bits at zero
`define CTS_ALIGN_BITS 2
`define CTS_ALIGN_ZERO 2'h0

// ahb-lite encodings
`define CTS_HTRANS_NONSEQ_BIT 1
`define CTS_HRESP_OKAY 1'b0
`define CTS_WORD_LSB 2

`endif

// File: cts_req_cell.v
`timescale 1ns/10ps
`include "cts_defs.vh"

module cts_req_cell
(
    input wire clk_sys,
    input wire rst_n,
    input wire set_one,
    input wire dir_tx,
    input wire all_sent,
    output reg send_request,
    output reg done_event
);

    reg next_send_request;

    // set by software only while transmitting, cleared only by hardware
    always @*
    begin
        next_send_request = send_request;
        if (send_request && all_sent)
        begin
            next_send_request = 1'b0;
        end
        if (set_one && dir_tx)
        begin
            next_send_request = 1'b1;
        end
    end

    // request bit and its completion pulse
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            send_request <= 1'b0;
            done_event <= 1'b0;
        end
        else
        begin
            send_request <= next_send_request;
            done_event <= send_request && all_sent && !(set_one && dir_tx);
        end
    end

endmodule

// File: cts_top.v
// Function
// - transmit summary bit set when enabled flags pend
// - summary is OR of enabled channel flags
// - summary index zero is the transmit queue
// - attempt summary follows attempts-exhausted flag
// - attempt index zero is queue, cleared elsewhere
// - writing one starts queued transmission
// - hardware clears request after all sent
// - writing zero never aborts, set-only bits
// - channels 1-7 set only when transmitting
// - receive-configured channel ignores request set
// - request bit zero serves transmit queue
// - transmit summary bits 8-31 read zero
// - request bits 8-31 read zero, ignore writes
// - attempt summary bits 8-31 read zero
// - upper base address register resets to zero
// - event FIFO at base, objects follow
// - base address low two bits read zero
`timescale 1ns/10ps
`include "cts_defs.vh"

module cts_top
#(
    parameter NCH = `CTS_NCH,
    parameter NFLG = `CTS_NFLG
)
(
    input wire clk_sys,
    input wire rst_n,
    input wire hsel,
    input wire [`CTS_AW-1:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [`CTS_DW-1:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [`CTS_DW-1:0] hrdata,
    output reg hresp,
    input wire [NCH*NFLG-1:0] chan_tx_flags,
    input wire [NCH*NFLG-1:0] chan_tx_flag_en,
    input wire [NCH-1:0] tx_attempts_flag,
    input wire [NCH-1:0] channel_direction_select,
    input wire [NCH-1:0] chan_all_sent,
    input wire [15:0] msg_memory_base_low,
    input wire [15:0] tef_size_bytes,
    output reg [NCH-1:0] send_request,
    output reg [`CTS_DW-1:0] tef_base_addr,
    output reg [`CTS_DW-1:0] object_base_addr,
    output reg irq
);

    localparam ST_IDLE = 2'b01;
    localparam ST_DATA = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [`CTS_AW-1:0] dp_addr;
    reg dp_write;
    reg [15:0] msg_memory_base_high;
    reg [`CTS_EV_W-1:0] ev_status;
    reg [`CTS_EV_W-1:0] next_ev_status;
    reg [`CTS_EV_W-1:0] ev_mask;
    reg [NCH-1:0] att_prev;
    reg [`CTS_DW-1:0] next_rdata;

    wire [NCH-1:0] tx_channel_irq_pending;
    wire [NCH-1:0] tx_attempts_irq_pending;
    wire [NCH-1:0] req_bits;
    wire [NCH-1:0] done_events;
    wire [NCH-1:0] att_rise;
    wire [NCH-1:0] dir_eff;
    wire [`CTS_EV_W-1:0] ev_set;
    wire addr_take;
    wire wr_req;
    wire rd_stat;
    wire [`CTS_DW-1:0] base_full;

    // a valid address phase while the bus is ready
    assign addr_take = hsel && hready && htrans[`CTS_HTRANS_NONSEQ_BIT];

    // data-phase write to the request register
    assign wr_req = (state == ST_DATA) && dp_write && (dp_addr == `CTS_OFF_SREQ_LO);

    // data-phase read of the event status register
    assign rd_stat = (state == ST_DATA) && !dp_write && (dp_addr == `CTS_OFF_EV_STAT);

    // the queue is always a transmit object
    assign dir_eff = {channel_direction_select[NCH-1:1], 1'b1};

    // per-channel summaries and request cells
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1)
        begin : g_chan
            // enabled flags only, combinational, no storage
            assign tx_channel_irq_pending[gi] =
                |(chan_tx_flags[gi*NFLG +: NFLG] & chan_tx_flag_en[gi*NFLG +: NFLG]);
            // index zero is the queue, others the fifos
            assign tx_attempts_irq_pending[gi] = tx_attempts_flag[gi];
            assign att_rise[gi] = tx_attempts_flag[gi] && !att_prev[gi];

            cts_req_cell u_req
            (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .set_one(wr_req && hwdata[gi]),
                .dir_tx(dir_eff[gi]),
                .all_sent(chan_all_sent[gi]),
                .send_request(req_bits[gi]),
                .done_event(done_events[gi])
            );
        end
    endgenerate

    // events for the sticky status register
    assign ev_set = {att_rise, done_events};

    // base address with the word alignment forced
    assign base_full = {msg_memory_base_high,
        msg_memory_base_low[15:`CTS_ALIGN_BITS], `CTS_ALIGN_ZERO};

    // bus state: one wait cycle per transfer
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (addr_take)
                begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA:
            begin
                next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // read mux, unimplemented bits read as zero
    always @*
    begin
        next_rdata = `CTS_RST_32;
        case (dp_addr)
            `CTS_OFF_TXIRQ_LO:
            begin
                next_rdata[NCH-1:0] = tx_channel_irq_pending;
            end
            `CTS_OFF_TXIRQ_HI:
            begin
                next_rdata = `CTS_RST_32;
            end
            `CTS_OFF_ATT_LO:
            begin
                next_rdata[NCH-1:0] = tx_attempts_irq_pending;
            end
            `CTS_OFF_ATT_HI:
            begin
                next_rdata = `CTS_RST_32;
            end
            `CTS_OFF_SREQ_LO:
            begin
                next_rdata[NCH-1:0] = req_bits;
            end
            `CTS_OFF_SREQ_HI:
            begin
                next_rdata = `CTS_RST_32;
            end
            `CTS_OFF_BASE_HI:
            begin
                next_rdata[15:0] = msg_memory_base_high;
            end
            `CTS_OFF_EV_STAT:
            begin
                next_rdata[`CTS_EV_W-1:0] = ev_status;
            end
            `CTS_OFF_EV_MASK:
            begin
                next_rdata[`CTS_EV_W-1:0] = ev_mask;
            end
            default:
            begin
                next_rdata = `CTS_RST_32;
            end
        endcase
    end

    // sticky events; a new event beats the read clear
    always @*
    begin
        next_ev_status = ev_status;
        if (rd_stat)
        begin
            next_ev_status = `CTS_EV_W'h0000;
        end
        next_ev_status = next_ev_status | ev_set;
    end

    // bus handshake, address capture and read data
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            dp_addr <= `CTS_RST_8;
            dp_write <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= `CTS_RST_32;
        end
        else
        begin
            state <= next_state;
            if (state == ST_IDLE && addr_take)
            begin
                dp_addr <= {haddr[`CTS_AW-1:`CTS_WORD_LSB], 2'h0};
                dp_write <= hwrite;
                hreadyout <= 1'b0;
            end
            else if (state == ST_DATA)
            begin
                hreadyout <= 1'b1;
                if (!dp_write)
                begin
                    hrdata <= next_rdata;
                end
            end
        end
    end

    // response is always okay, no error path
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hresp <= `CTS_HRESP_OKAY;
        end
        else
        begin
            hresp <= `CTS_HRESP_OKAY;
        end
    end

    // upper base address half, read/write
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            msg_memory_base_high <= `CTS_RST_16;
        end
        else if (state == ST_DATA && dp_write && dp_addr == `CTS_OFF_BASE_HI)
        begin
            msg_memory_base_high <= hwdata[15:0];
        end
    end

    // interrupt mask, same layout as event status
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ev_mask <= `CTS_RST_16;
        end
        else if (state == ST_DATA && dp_write && dp_addr == `CTS_OFF_EV_MASK)
        begin
            ev_mask <= hwdata[`CTS_EV_W-1:0];
        end
    end

    // sticky event status
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ev_status <= `CTS_RST_16;
        end
        else
        begin
            ev_status <= next_ev_status;
        end
    end

    // previous attempt flags for rise detection
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            att_prev <= {NCH{1'b0}};
        end
        else
        begin
            att_prev <= tx_attempts_flag;
        end
    end

    // level interrupt, in step with the status register
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(next_ev_status & ev_mask);
        end
    end

    // request bits toward the protocol engine
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            send_request <= {NCH{1'b0}};
        end
        else
        begin
            send_request <= req_bits;
        end
    end

    // transmit event fifo starts at the base
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tef_base_addr <= `CTS_RST_32;
        end
        else
        begin
            tef_base_addr <= base_full;
        end
    end

    // message objects follow the event fifo
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            object_base_addr <= `CTS_RST_32;
        end
        else
        begin
            object_base_addr <= base_full + {16'h0000, tef_size_bytes};
        end
    end

endmodule

// File: cts_chk.sv
`timescale 1ns/10ps
`include "cts_defs.vh"
module cts_chk
#(
    parameter NCH = 8,
    parameter NFLG = 3
)
(
    input logic clk_sys,
    input logic rst_n,
    input logic hsel,
    input logic [1:0] htrans,
    input logic hready,
    input logic hreadyout,
    input logic hresp,
    input logic [NCH-1:0] channel_direction_select,
    input logic [NCH-1:0] chan_all_sent,
    input logic [15:0] msg_memory_base_low,
    input logic [15:0] tef_size_bytes,
    input logic [NCH-1:0] send_request,
    input logic [`CTS_DW-1:0] tef_base_addr,
    input logic [`CTS_DW-1:0] object_base_addr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // bus transfer timing and response
    AST_READY_PULSE:
        assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
        else $error("ready pulse wrong");
    AST_HRESP_OKAY:
        assert property (hresp == `CTS_HRESP_OKAY) else $error("resp not okay");
    // request bits fall only after all sent
    AST_REQ_HOLD:
        assert property (($past(send_request) & ~send_request & ~$past(chan_all_sent, 2)) == 0)
        else $error("request dropped early");
    AST_REQ_CLEAR:
        assert property ((send_request & $past(send_request) & $past(chan_all_sent, 2)
            & $past(chan_all_sent, 3)) == 0) else $error("request not cleared");
    // fifo request bits rise only in transmit direction
    AST_REQ_DIR:
        assert property ((send_request & ~$past(send_request)
            & ~$past(channel_direction_select, 2) & 8'hFE) == 0) else $error("rx set");
    // base address outputs
    AST_BASE_ALIGN:
        assert property (tef_base_addr[1:0] == `CTS_ALIGN_ZERO) else $error("base unaligned");
    AST_TEF_LOW:
        assert property ($past(rst_n) && $stable(msg_memory_base_low)
            |-> tef_base_addr[15:2] == msg_memory_base_low[15:2]) else $error("tef base");
    AST_OBJ_BASE:
        assert property ($past(rst_n, 2) && $stable(tef_size_bytes)
            && tef_base_addr == $past(tef_base_addr) && tef_base_addr == $past(tef_base_addr, 2)
            |-> object_base_addr == tef_base_addr + tef_size_bytes) else $error("obj base");
    // main scenarios
    cover property ($rose(send_request[0]));
    cover property ($fell(send_request[3]));
    cover property (!hreadyout);
endmodule

// File: cts_can_node.sv
`timescale 1ns/10ps
module cts_can_node
(
    input logic clk_sys,
    input logic rst_n,
    input logic [7:0] send_request,
    input logic [7:0] delay,
    output logic [7:0] chan_all_sent
);
    logic [7:0] age [8];
    // bus time spent on each pending channel
    always @(posedge clk_sys or negedge rst_n)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!rst_n || !send_request[i])
                age[i] <= 8'h00;
            else if (age[i] != 8'hFF)
                age[i] <= age[i] + 8'h01;
        end
    end
    // frames done once delay has passed
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            chan_all_sent[i] = send_request[i] && age[i] >= delay;
    end
endmodule

// File: can_tx_summary_and_request_tb.sv
`timescale 1ns/10ps
`include "cts_defs.vh"
module can_tx_summary_and_request_tb;
    logic clk_sys, rst_n, hsel, hwrite, hreadyout, hresp, irq;
    logic [1:0] htrans;
    logic [7:0] haddr, dir, att, sreq, sent, dly;
    logic [31:0] hwdata, hrdata, tef, obj, rd;
    logic [23:0] fl, en, p;
    logic [15:0] low, size;
    int failures, samples_checked, cycles;
    cts_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .chan_tx_flags(fl),
        .chan_tx_flag_en(en), .tx_attempts_flag(att), .channel_direction_select(dir),
        .chan_all_sent(sent), .msg_memory_base_low(low), .tef_size_bytes(size),
        .send_request(sreq), .tef_base_addr(tef), .object_base_addr(obj), .irq(irq));
    cts_can_node u_node (.clk_sys(clk_sys), .rst_n(rst_n), .send_request(sreq),
        .delay(dly), .chan_all_sent(sent));
    // clock and hang guard
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            final_report();
        end
    end
    task automatic final_report();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one single ahb-lite transfer
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    task automatic t_reset();
        for (int a = 0; a < 40; a += 4)
            rdc(a[7:0], 32'h0000_0000);
    endtask
    task automatic t_summary();
        for (int c = 0; c < 8; c++)
        begin
            p = 24'h1 << (c * 3 + c % 3);
            fl <= p;
            en <= p;
            rdc(`CTS_OFF_TXIRQ_LO, 32'h1 << c);
            en <= ~p;
            rdc(`CTS_OFF_TXIRQ_LO, 32'h0000_0000);
        end
        en <= 24'hFF_FFFF;
        bus(1'b1, `CTS_OFF_TXIRQ_LO, 32'hFFFF_FFFF);
        rdc(`CTS_OFF_TXIRQ_LO, 32'h0000_0080);
        rdc(`CTS_OFF_TXIRQ_HI, 32'h0000_0000);
        fl <= 24'h00_0000;
        rdc(`CTS_OFF_TXIRQ_LO, 32'h0000_0000);
    endtask
    task automatic t_attempt();
        bus(1'b1, `CTS_OFF_EV_MASK, 32'h0000_0100);
        att <= 8'hA5;
        rdc(`CTS_OFF_ATT_LO, 32'h0000_00A5);
        rdc(`CTS_OFF_ATT_HI, 32'h0000_0000);
        chk(irq, 1'b1);
        rdc(`CTS_OFF_EV_STAT, 32'h0000_A500);
        @(posedge clk_sys);
        chk(irq, 1'b0);
        att <= 8'h00;
    endtask
    task automatic t_request();
        dir <= 8'h0E;
        bus(1'b1, `CTS_OFF_SREQ_LO, 32'hFFFF_FFFF);
        rdc(`CTS_OFF_SREQ_LO, 32'h0000_000F);
        chk(sreq, 32'h0000_000F);
        bus(1'b1, `CTS_OFF_SREQ_LO, 32'h0000_0000);
        rdc(`CTS_OFF_SREQ_LO, 32'h0000_000F);
        rdc(`CTS_OFF_SREQ_HI, 32'h0000_0000);
        for (int n = 0; n < 100 && sreq !== 8'h00; n++)
            @(posedge clk_sys);
        rdc(`CTS_OFF_SREQ_LO, 32'h0000_0000);
        rdc(`CTS_OFF_EV_STAT, 32'h0000_000F);
    endtask
    task automatic t_base();
        low <= 16'hABCF;
        size <= 16'h0100;
        bus(1'b1, `CTS_OFF_BASE_HI, 32'hFFFF_1234);
        rdc(`CTS_OFF_BASE_HI, 32'h0000_1234);
        repeat (3) @(posedge clk_sys);
        chk(tef, 32'h1234_ABCC);
        chk(obj, 32'h1234_ACCC);
    endtask
    // reset, then each scenario in turn
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {fl, en, att, dir, low, size, rst_n} = '0;
        dly = 8'd20;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_summary();
        t_attempt();
        t_request();
        t_base();
        final_report();
    end
endmodule
bind cts_top cts_chk #(.NCH(NCH), .NFLG(NFLG)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .channel_direction_select(channel_direction_select), .chan_all_sent(chan_all_sent),
    .msg_memory_base_low(msg_memory_base_low), .tef_size_bytes(tef_size_bytes),
    .send_request(send_request), .tef_base_addr(tef_base_addr),
    .object_base_addr(object_base_addr));
